/* File: hw/aap_arm_pcm.sv */
// arming evaluation, pulse stretch and pulse-code output for one axis
module aap_arm_pcm #(
    parameter int STRETCH_CYC = aap_pkg::STRETCH_UNIT_CYC  // cycles per stretch step
) (
    input  wire logic                          ref_clk,
    input  wire logic                          rst,
    input  wire logic                          cs_n_pin,
    input  wire logic                          accel_req,
    input  wire logic                          accel_resp,
    input  wire logic                          error_lock,
    input  wire logic signed [aap_pkg::SAMPLE_W-1:0] sample,
    input  wire logic [2:0]                    mode,
    input  wire logic [1:0]                    arm_window_size,
    input  wire logic [1:0]                    arm_stretch_time,
    input  wire logic signed [aap_pkg::THR_W-1:0] thr_pos,
    input  wire logic signed [aap_pkg::THR_W-1:0] thr_neg,
    output logic                               arm_pin,
    output logic                               arm_flag,
    output logic [aap_pkg::SAMPLE_W-1:0]       sample_latched
);
    import aap_pkg::*;

    // ************************************************************
    // helper functions
    // ************************************************************

    // signed compare against both thresholds, lsb aligned to sample bit 4
    function automatic logic thr_hit(input logic signed [SAMPLE_W-1:0] v,
                                     input logic signed [THR_W-1:0] p,
                                     input logic signed [THR_W-1:0] n);
        logic signed [SAMPLE_W-1:0] ps;
        logic signed [SAMPLE_W-1:0] ns;
        ps = SAMPLE_W'(p) <<< THR_SHIFT;
        ns = SAMPLE_W'(n) <<< THR_SHIFT;
        return (v >= ps) || (v <= ns);
    endfunction

    // window or count limit length for a 2-bit code: 1, 2, 4, 8
    function automatic logic [CNT_W-1:0] code_len(input logic [1:0] c);
        return CNT_W'(1) << c;
    endfunction

    // ************************************************************
    // chip select synchroniser and rise detect
    // ************************************************************
    logic cs_meta;        // first stage, read only by cs_sync
    logic cs_sync;        // synchronised chip select (low = active)
    logic cs_prev;        // previous synchronised level

    // two flops then an edge register
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cs_meta <= 1'b1;
            cs_sync <= 1'b1;
            cs_prev <= 1'b1;
        end else begin
            cs_meta <= cs_n_pin;
            cs_sync <= cs_meta;
            cs_prev <= cs_sync;
        end
    end

    logic cs_rise;        // end of a transfer
    logic req_rise;       // end of an acceleration request
    assign cs_rise  = cs_sync & ~cs_prev;
    assign req_rise = cs_rise & accel_req;

    // ************************************************************
    // mode decode
    // ************************************************************
    logic is_ma;          // moving average mode
    logic is_cnt;         // count mode
    logic is_unf;         // unfiltered mode
    logic is_pcm;         // pulse-code mode
    logic act_low;        // pin polarity
    logic [2:0] mode_prev;  // mode seen last cycle
    logic mode_chg;       // mode changed this cycle

    assign is_ma   = (mode == MODE_MA_HI)  || (mode == MODE_MA_LO);
    assign is_cnt  = (mode == MODE_CNT_HI) || (mode == MODE_CNT_LO);
    assign is_unf  = (mode == MODE_UNF_HI) || (mode == MODE_UNF_LO);
    assign is_pcm  = (mode == MODE_PCM);
    assign act_low = mode[2] & ~is_pcm;
    assign mode_chg = (mode != mode_prev);

    // remember mode to spot changes
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            mode_prev <= RST_MODE;
        end else begin
            mode_prev <= mode;
        end
    end

    // evaluation strobe: a request ends, arming active, no error
    logic eval;
    assign eval = req_rise & ~error_lock & (is_ma | is_cnt | is_unf) & ~mode_chg;

    // ************************************************************
    // sample capture for the next response
    // ************************************************************
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sample_latched <= '0;
        end else if (req_rise) begin
            sample_latched <= sample;
        end
    end

    // ************************************************************
    // moving average history
    // ************************************************************
    logic signed [SAMPLE_W-1:0] hist [HIST_MAX];       // newest at index 0
    logic signed [SAMPLE_W-1:0] next_hist [HIST_MAX];  // history with new sample
    logic signed [SAMPLE_W+2:0] ma_sum;                // sum over window
    logic signed [SAMPLE_W-1:0] ma_avg;                // window average

    // shift the new sample in and average the first k entries
    always_comb begin
        next_hist[0] = sample;
        for (int i = 1; i < HIST_MAX; i++) begin
            next_hist[i] = hist[i-1];
        end
        ma_sum = '0;
        for (int i = 0; i < HIST_MAX; i++) begin
            if (i < int'(code_len(arm_window_size))) begin
                ma_sum = ma_sum + (SAMPLE_W+3)'(next_hist[i]);
            end
        end
        ma_avg = SAMPLE_W'(ma_sum >>> arm_window_size);
    end

    // history register, cleared on mode change
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < HIST_MAX; i++) begin
                hist[i] <= '0;
            end
        end else if (mode_chg) begin
            for (int i = 0; i < HIST_MAX; i++) begin
                hist[i] <= '0;
            end
        end else if (eval && is_ma) begin
            hist <= next_hist;
        end
    end

    // ************************************************************
    // consecutive-sample counter
    // ************************************************************
    logic [CNT_W-1:0] cnt;       // consecutive hits
    logic [CNT_W-1:0] next_cnt;  // count after this sample
    logic             hit_raw;   // this sample beyond a threshold

    assign hit_raw  = thr_hit(sample, thr_pos, thr_neg);
    assign next_cnt = hit_raw ? ((cnt == code_len(arm_window_size)) ? cnt : cnt + 1'b1) : '0;

    // counter register
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cnt <= '0;
        end else if (mode_chg) begin
            cnt <= '0;
        end else if (eval && is_cnt) begin
            cnt <= next_cnt;
        end
    end

    // ************************************************************
    // arming condition
    // ************************************************************
    logic next_cond;  // condition from the sample being evaluated

    // pick the condition for the active mode
    always_comb begin
        if (is_ma) begin
            next_cond = thr_hit(ma_avg, thr_pos, thr_neg);
        end else if (is_cnt) begin
            next_cond = (next_cnt >= code_len(arm_window_size));
        end else if (is_unf) begin
            next_cond = hit_raw;
        end else begin
            next_cond = 1'b0;
        end
    end

    // condition after the most recently evaluated sample
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            arm_flag <= 1'b0;
        end else if (mode_chg) begin
            arm_flag <= 1'b0;
        end else if (eval) begin
            arm_flag <= next_cond;
        end
    end

    // ************************************************************
    // pulse stretch timer
    // ************************************************************
    localparam int TMR_W = $clog2(3 * STRETCH_CYC + 1);  // fits the longest stretch
    logic [TMR_W-1:0] tmr;      // remaining stretch cycles
    logic [TMR_W-1:0] tmr_load; // programmed stretch length

    assign tmr_load = TMR_W'(STRETCH_CYC) * TMR_W'(arm_stretch_time);

    // load on arming, otherwise count down to zero
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            tmr <= '0;
        end else if (mode_chg) begin
            tmr <= '0;
        end else if (eval && next_cond && (is_ma || is_cnt) && (arm_stretch_time != 2'h0)) begin
            tmr <= tmr_load;
        end else if (tmr != '0) begin
            tmr <= tmr - 1'b1;
        end
    end

    // ************************************************************
    // pulse-code output
    // ************************************************************
    logic [2:0]       div;       // 40 MHz to 8 MHz divider
    logic             pcm_en;    // accumulator step enable
    logic [PCM_W-1:0] acc;       // accumulator
    logic             pcm_bit;   // registered carry
    logic [PCM_W-1:0] pcm_val;   // unsigned saturated sample
    logic [PCM_W:0]   acc_sum;   // accumulator sum with carry

    assign pcm_en = (div == 3'(PCM_DIV - 1));

    // saturate to nine signed bits, then offset to unsigned
    always_comb begin
        if (sample > SAMPLE_W'(255)) begin
            pcm_val = 9'h1ff;
        end else if (sample < -SAMPLE_W'(256)) begin
            pcm_val = 9'h000;
        end else begin
            pcm_val = {~sample[8], sample[7:0]};
        end
    end

    assign acc_sum = {1'b0, acc} + {1'b0, pcm_val};

    // divider for the accumulator rate
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            div <= RST_DIV;
        end else begin
            div <= pcm_en ? RST_DIV : div + 1'b1;
        end
    end

    // accumulate and keep the carry
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            acc     <= RST_ACC;
            pcm_bit <= 1'b0;
        end else if (!is_pcm) begin
            acc     <= RST_ACC;
            pcm_bit <= 1'b0;
        end else if (pcm_en) begin
            acc     <= acc_sum[PCM_W-1:0];
            pcm_bit <= acc_sum[PCM_W];
        end
    end

    // ************************************************************
    // pin drive
    // ************************************************************
    logic arm_level;  // asserted level before polarity

    // choose the source of the arming level
    always_comb begin
        if (is_ma || is_cnt) begin
            arm_level = (arm_stretch_time == 2'h0) ? arm_flag : (tmr != '0);
        end else if (is_unf) begin
            arm_level = arm_flag & ~cs_sync & accel_resp;
        end else begin
            arm_level = 1'b0;
        end
    end

    // registered pin, pulse code or polarised arming
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            arm_pin <= 1'b0;
        end else if (is_pcm) begin
            arm_pin <= pcm_bit;
        end else if (mode == MODE_OFF) begin
            arm_pin <= 1'b0;
        end else begin
            arm_pin <= arm_level ^ act_low;
        end
    end

endmodule

/* File: hw/aap_pkg.sv */
// constants shared by the arming and pulse-code output block
package aap_pkg;

    // ******************************************
    // widths
    // ******************************************
    localparam int SAMPLE_W = 12;             // offset-cancelled sample width
    localparam int THR_W    = 8;              // threshold width
    localparam int THR_SHIFT = 4;             // threshold lsb sits at sample bit 4
    localparam int PCM_W    = 9;              // pulse-code accumulator width
    localparam int HIST_MAX = 8;              // deepest averaging window
    localparam int CNT_W    = 4;              // consecutive-sample counter width

    // ******************************************
    // mode field encodings
    // ******************************************
    localparam logic [2:0] MODE_OFF    = 3'h0;  // arming disabled, pin idle
    localparam logic [2:0] MODE_MA_HI  = 3'h1;  // moving average, active high
    localparam logic [2:0] MODE_CNT_HI = 3'h2;  // count, active high
    localparam logic [2:0] MODE_UNF_HI = 3'h3;  // unfiltered, active high
    localparam logic [2:0] MODE_PCM    = 3'h4;  // pulse-code output
    localparam logic [2:0] MODE_MA_LO  = 3'h5;  // moving average, active low
    localparam logic [2:0] MODE_CNT_LO = 3'h6;  // count, active low
    localparam logic [2:0] MODE_UNF_LO = 3'h7;  // unfiltered, active low

    // ******************************************
    // timing
    // ******************************************
    localparam int CLK_HZ          = 40_000_000;           // ref_clk rate
    localparam int PCM_HZ          = 8_000_000;            // accumulator rate
    localparam int PCM_DIV         = CLK_HZ / PCM_HZ;      // ref_clk cycles per accumulator step
    localparam int STRETCH_UNIT_MS = 10;                   // stretch step per code
    localparam int STRETCH_UNIT_CYC = CLK_HZ / 1000 * STRETCH_UNIT_MS;  // cycles per stretch step

    // ******************************************
    // reset values
    // ******************************************
    localparam logic [2:0]  RST_MODE  = MODE_OFF;  // mode register after reset
    localparam logic [PCM_W-1:0] RST_ACC = 9'h000; // accumulator after reset
    localparam logic [2:0]  RST_DIV   = 3'h0;      // divider after reset

endpackage

/* File: verif/aap_arm_checker.sv */
// port assertions for the arming and pulse-code block
module aap_arm_checker (
    input wire logic                                 ref_clk,
    input wire logic                                 rst,
    input wire logic                                 cs_n_pin,
    input wire logic                                 accel_req,
    input wire logic                                 error_lock,
    input wire logic signed [aap_pkg::SAMPLE_W-1:0]  sample,
    input wire logic [2:0]                           mode,
    input wire logic [1:0]                           arm_stretch_time,
    input wire logic                                 arm_pin,
    input wire logic                                 arm_flag,
    input wire logic [aap_pkg::SAMPLE_W-1:0]         sample_latched
);
    import aap_pkg::*;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    AST_OFF_IDLE: assert property (mode == MODE_OFF && $past(mode) == MODE_OFF |-> !arm_pin)
        else $error("pin active while disabled");
    AST_MODE_CLEAR: assert property (mode != $past(mode) |=> !arm_flag)
        else $error("flag kept over mode change");
    AST_LATCH: assert property ($changed(sample_latched) |-> $past(accel_req) && sample_latched == $past(sample))
        else $error("latched sample wrong");
    AST_FLAG_NEEDS_REQ: assert property ($rose(arm_flag) |-> $past(accel_req) && !$past(error_lock))
        else $error("flag rose without request");
    AST_ERR_HOLD: assert property (error_lock && $stable(mode) |=> $stable(arm_flag))
        else $error("evaluation under error");
    AST_UNF_NO_STRETCH: assert property ((mode == MODE_UNF_HI && cs_n_pin) [*5] |-> !arm_pin)
        else $error("unfiltered pin outside transfer");
    AST_ZERO_STRETCH: assert property (mode == MODE_MA_HI && $stable(mode)
        && $past(arm_stretch_time) == 2'h0 |-> arm_pin == $past(arm_flag))
        else $error("pin does not follow flag");
    AST_STRETCH_HOLD: assert property ($rose(arm_pin) && mode == MODE_CNT_HI && arm_stretch_time != 2'h0
        |-> arm_pin [*8])
        else $error("stretched pin dropped early");
    AST_PCM_STEP: assert property (mode == MODE_PCM && $past(mode) == MODE_PCM && $past(mode, 2) == MODE_PCM
        && $changed(arm_pin) |=> $stable(arm_pin) [*4])
        else $error("pulse-code step not five clocks");
endmodule

/* File: verif/aap_spi_host.sv */
// spi host model: one transfer per go pulse, an acceleration request when accel is high
module aap_spi_host (
    input  wire logic ref_clk,
    input  wire logic go,
    input  wire logic accel,
    output logic      cs_n_pin,
    output logic      accel_req,
    output logic      accel_resp,
    output logic      busy
);
    logic [4:0] step = 5'h00;  // position in the request cycle, 0 idle
    // select low for steps 1-6, then idle long enough for the minimum spacing
    always @(posedge ref_clk) begin
        if (step == 5'h00) begin
            if (go) step <= 5'h01;
        end else begin
            step <= (step == 5'h14) ? 5'h00 : step + 5'h01;
        end
    end
    assign busy       = (step != 5'h00) || go;
    assign cs_n_pin   = !(step >= 5'h01 && step <= 5'h06);
    assign accel_resp = accel && !cs_n_pin;                         // response rides this transfer
    assign accel_req  = accel && (step >= 5'h07 && step <= 5'h0b);  // low accel: a register transfer
endmodule

/* File: verif/tb_top.sv */
// self-checking bench for the arming and pulse-code block
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import aap_pkg::*;
    localparam int STR = 20;                               // shortened stretch step
    logic ref_clk = 1'b0, rst = 1'b1, go = 1'b0, error_lock = 1'b0, accel = 1'b1, mid;
    logic signed [SAMPLE_W-1:0] sample = 12'sh000;
    logic [2:0] mode = MODE_OFF;
    logic [1:0] ws = 2'h0, st = 2'h0;
    logic signed [THR_W-1:0] thr_pos = 8'sh10, thr_neg = -8'sh10;
    logic cs_n_pin, accel_req, accel_resp, busy, arm_pin, arm_flag;
    logic [SAMPLE_W-1:0] sample_latched;
    int failures = 0, comparisons = 0, cycles = 0;
    always #12.5 ref_clk = ~ref_clk;
    aap_arm_pcm #(.STRETCH_CYC(STR)) dut (.ref_clk(ref_clk), .rst(rst), .cs_n_pin(cs_n_pin), .accel_req(accel_req),
        .accel_resp(accel_resp), .error_lock(error_lock), .sample(sample), .mode(mode), .arm_window_size(ws),
        .arm_stretch_time(st), .thr_pos(thr_pos), .thr_neg(thr_neg), .arm_pin(arm_pin), .arm_flag(arm_flag),
        .sample_latched(sample_latched));
    aap_spi_host host (.ref_clk(ref_clk), .go(go), .accel(accel), .cs_n_pin(cs_n_pin), .accel_req(accel_req),
        .accel_resp(accel_resp), .busy(busy));
    // cut a hang short
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            failures++;
            summarize();
        end
    end
    function automatic bit c(input bit mism);
        comparisons++;
        return mism;
    endfunction
    task automatic bad(input string m);
        failures++;
        $display("[FAIL] %0t %s", $time, m);
    endtask
    task automatic summarize();
        if (failures == 0 && comparisons > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // one request; mid holds the pin seen while selected
    task automatic req(input logic signed [SAMPLE_W-1:0] v);
        int n;
        @(posedge ref_clk);
        sample <= v;
        go <= 1'b1;
        @(posedge ref_clk);
        go <= 1'b0;
        repeat (4) @(posedge ref_clk);
        #1;
        mid = arm_pin;
        n = 0;
        while (busy && n < 40) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
    endtask
    // cycles the pin stays high after a request returns
    task automatic hold(output int n);
        n = 0;
        while (arm_pin === 1'b1 && n < 200) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
    endtask
    // window and stretch change only while disabled
    task automatic set_mode(input logic [2:0] m, input logic [1:0] w, input logic [1:0] s);
        @(posedge ref_clk);
        mode <= MODE_OFF;
        ws <= w;
        st <= s;
        repeat (3) @(posedge ref_clk);
        mode <= m;
        repeat (3) @(posedge ref_clk);
        #1;
    endtask
    task automatic t_unf();
        logic signed [SAMPLE_W-1:0] v[4] = '{12'sh100, 12'sh0ff, -12'sh100, -12'sh0ff};
        set_mode(MODE_UNF_HI, 2'h0, 2'h2);
        for (int i = 0; i < 4; i++) begin
            req(v[i]);
            if (c(arm_flag !== ~i[0])) bad("unfiltered flag");
            if (c(mid !== i[0])) bad("unfiltered pin in transfer");
            if (c(arm_pin !== 1'b0)) bad("unfiltered pin stretched");
            if (c(sample_latched !== v[i])) bad("latched sample");
        end
    endtask
    task automatic t_ma();
        logic signed [SAMPLE_W-1:0] v[5] = '{12'sh100, 12'sh100, 12'sh000, 12'sh12c, 12'sh0d4};
        logic [4:0] e = 5'h12;
        int n;
        set_mode(MODE_MA_HI, 2'h1, 2'h0);
        for (int i = 0; i < 5; i++) begin
            req(v[i]);
            if (i > 0 && c(arm_flag !== e[i])) bad("average flag");
            if (i > 0 && c(arm_pin !== e[i])) bad("average pin");
        end
        @(posedge ref_clk);
        sample <= 12'sh000;
        repeat (8) @(posedge ref_clk);
        #1;
        if (c(arm_flag !== 1'b1)) bad("flag moved without request");
        @(posedge ref_clk);
        accel <= 1'b0;
        req(-12'sh100);
        if (c(arm_flag !== 1'b1 || sample_latched !== 12'h0d4)) bad("register transfer evaluated");
        @(posedge ref_clk);
        accel <= 1'b1;
        set_mode(MODE_MA_HI, 2'h2, 2'h3);
        for (int i = 0; i < 4; i++) begin
            req(12'sh100);
            if (c(arm_flag !== (i == 3))) bad("four-sample average");
        end
        hold(n);
        if (c(n !== 3 * STR - 10)) bad("average stretch length");
    endtask
    task automatic t_cnt();
        logic signed [SAMPLE_W-1:0] v[4] = '{12'sh12c, 12'sh000, 12'sh12c, 12'sh12c};
        int n;
        set_mode(MODE_CNT_HI, 2'h1, 2'h2);
        for (int i = 0; i < 4; i++) begin
            req(v[i]);
            if (c(arm_flag !== (i == 3))) bad("count flag");
        end
        hold(n);
        if (c(n !== 2 * STR - 10)) bad("stretch length");
        if (c(arm_flag !== 1'b1 || arm_pin !== 1'b0)) bad("pin not timer driven");
        @(posedge ref_clk);
        error_lock <= 1'b1;
        req(12'sh000);
        if (c(arm_flag !== 1'b1)) bad("evaluated under error");
        req(12'sh12c);
        if (c(arm_pin !== 1'b0)) bad("stretch reloaded under error");
        @(posedge ref_clk);
        error_lock <= 1'b0;
        req(12'sh12c);
        if (c(arm_pin !== 1'b1)) bad("stretch not reloaded");
        set_mode(MODE_OFF, 2'h0, 2'h0);
        if (c(arm_flag !== 1'b0 || arm_pin !== 1'b0)) bad("disable kept state");
        set_mode(MODE_CNT_HI, 2'h3, 2'h1);
        for (int i = 0; i < 8; i++) begin
            req(12'sh12c);
            if (c(arm_flag !== (i == 7))) bad("eight-sample count");
        end
        hold(n);
        if (c(n !== STR - 10)) bad("short stretch length");
    endtask
    task automatic t_lo();
        logic [2:0] m[3] = '{MODE_MA_LO, MODE_CNT_LO, MODE_UNF_LO};
        for (int i = 0; i < 3; i++) begin
            set_mode(m[i], 2'h0, 2'h0);
            req(12'sh000);
            if (c(arm_pin !== 1'b1)) bad("active low idle");
            req(-12'sh100);
            if (c(arm_flag !== 1'b1 || arm_pin !== (i == 2))) bad("active low armed");
        end
    endtask
    task automatic t_pcm();
        logic signed [SAMPLE_W-1:0] v[3] = '{12'sh000, 12'sh7ff, 12'sh800};
        int u;
        int n;
        set_mode(MODE_PCM, 2'h0, 2'h0);
        for (int i = 0; i < 3; i++) begin
            @(posedge ref_clk);
            sample <= v[i];
            repeat (20) @(posedge ref_clk);
            u = (v[i] > 255) ? 511 : (v[i] < -256) ? 0 : v[i] + 256;
            n = 0;
            repeat (512 * PCM_DIV) begin
                @(posedge ref_clk);
                #1;
                n += (arm_pin === 1'b1);
            end
            if (c(n > u * PCM_DIV + 10 || n < u * PCM_DIV - 10)) bad("pulse density");
        end
    endtask
    initial begin
        repeat (10) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (3) @(posedge ref_clk);
        t_unf();
        t_ma();
        t_cnt();
        t_lo();
        t_pcm();
        summarize();
    end
endmodule
bind aap_arm_pcm aap_arm_checker chk (.ref_clk(ref_clk), .rst(rst), .cs_n_pin(cs_n_pin), .accel_req(accel_req),
    .error_lock(error_lock), .sample(sample), .mode(mode), .arm_stretch_time(arm_stretch_time),
    .arm_pin(arm_pin), .arm_flag(arm_flag), .sample_latched(sample_latched));
